//--- shared/cam_pkg.sv
// Shared constants and types of the channel alarm output mapper.
`default_nettype none
package cam_pkg;

  // Channel count, reading width and output line count.
  localparam int MAX_CH = 32;
  localparam int RDG_W = 16;
  localparam int NUM_LINES = 16;
  localparam int PORT_LINES = 4;

  // Register byte offsets on the Wishbone slave.
  localparam logic [7:0] REG_CFG_CMD = 8'h00;
  localparam logic [7:0] REG_LIMITS = 8'h04;
  localparam logic [7:0] REG_ASSIGN_CMD = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0c;
  localparam logic [7:0] REG_OUT_STATUS = 8'h10;
  localparam logic [7:0] REG_CHAN_ALARM = 8'h14;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h18;
  localparam logic [7:0] REG_IRQ_MASK = 8'h1c;

  // Field positions inside the command, limits, control and interrupt registers.
  localparam int CMD_FIRST_LSB = 0;
  localparam int CMD_LAST_LSB = 8;
  localparam int CMD_ARG_LSB = 16;
  localparam int LIM_LOW_LSB = 0;
  localparam int LIM_HIGH_LSB = 16;
  localparam int CTRL_SRQ_EN_BIT = 0;
  localparam int IRQ_ENTER_BIT = 0;
  localparam int IRQ_LEAVE_BIT = 1;

  // Values after reset.
  localparam logic [31:0] LIMITS_RST = 32'h0000_0000;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  // State of one channel comparator.
  typedef struct packed {
    logic en;
    logic signed [RDG_W-1:0] high;
    logic signed [RDG_W-1:0] low;
    logic alarm;
  } cam_chan_t;

  // Whole state of the mapper top.
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [31:0] limits;
    logic srq_en;
    logic [NUM_LINES-1:0][MAX_CH-1:0] map;
    logic [NUM_LINES-1:0] lines;
    logic sys_alarm;
    logic srq;
    logic start_ev;
    logic stop_ev;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
  } cam_state_t;

endpackage : cam_pkg
`default_nettype wire

//--- src/cam_chan.sv
// One channel's alarm comparator with its limits and enable.
`timescale 1ns/1ns
`default_nettype none
module cam_chan (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic cfg_we_i,
  input wire logic cfg_alarm_en_i,
  input wire logic [cam_pkg::RDG_W-1:0] cfg_high_i,
  input wire logic [cam_pkg::RDG_W-1:0] cfg_low_i,
  input wire logic rdg_valid_i,
  input wire logic [cam_pkg::RDG_W-1:0] rdg_value_i,
  output logic alarm_o
);
  import cam_pkg::*;

  cam_chan_t st_ff;
  cam_chan_t nxt_st;

  // A configure write arms or disarms at once; a reading updates the flag.
  always_comb begin
    nxt_st = st_ff;
    if (cfg_we_i) begin
      nxt_st.en = cfg_alarm_en_i;
      nxt_st.high = cfg_high_i;
      nxt_st.low = cfg_low_i;
      // Drop any stale flag so new limits start from a clean state.
      nxt_st.alarm = 1'b0;
    end else if (rdg_valid_i) begin
      nxt_st.alarm = st_ff.en &&
        (($signed(rdg_value_i) > st_ff.high) ||
         ($signed(rdg_value_i) < st_ff.low));
    end
  end

  // Register the comparator state.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign alarm_o = st_ff.alarm;

endmodule : cam_chan
`default_nettype wire

//--- src/cam_mapper.sv
// Alarm mapper top: channel limits, line mapping, status and service request.
//
// Function
// - The configure command adds a channel range and, with alarm fields, enables alarm checking on it.
// - A reading above the high limit or below the low limit on an armed channel puts the device in alarm.
// - Alarm checking is live as soon as the configure command is done, with no extra arming step.
// - Channel alarms can also drive any one of sixteen digital output lines.
// - The assign command maps a channel range onto one line, which is the OR of those channels' alarms.
// - The output status query reports the state of all lines of all four output ports.
// - The per-channel alarm query gives a separate alarm flag for every channel.
// - With the alarm service request enable set, the device raises service request when in alarm.
// - The controller serial-polls first and the device releases service request on that poll.
// - Channel alarms serve as acquisition start and stop events, armed by limits alone.
//
// Register map, byte offsets on the Wishbone slave:
// 0x00 configure command, write only: bits 4:0 first channel, bits 12:8
//      last channel, bit 16 alarm enable. It loads the limits word into
//      every channel of the range and clears their alarm flags.
// 0x04 limits: signed low limit in bits 15:0, signed high limit in bits
//      31:16. Write it before the configure command that uses it.
// 0x08 assign command, write only: bits 4:0 first channel, bits 12:8 last
//      channel, bits 19:16 output line, zero for line one.
// 0x0c control: bit 0 is the alarm service request enable.
// 0x10 output status: byte p is the weighted sum of the lines of port p.
// 0x14 channel alarm status: bit c is set while channel c is in alarm.
// 0x18 interrupt status, cleared by its read: bit 0 alarm entered, bit 1
//      alarm left. An event in the clearing cycle is kept.
// 0x1c interrupt mask, same layout as the status.
// Unmapped offsets are answered, read as zero and ignore writes.
//
// Every access is answered one cycle after it is taken. A master that
// keeps its request up after the answer starts a second access, so two
// answers are separated by at least one idle cycle.
// Readings arrive one channel per valid cycle; the alarm lines, system
// alarm and events follow two cycles after the reading.
`timescale 1ns/1ns
`default_nettype none
module cam_mapper #(
  parameter int CHANNELS = cam_pkg::MAX_CH
) (
  input wire logic clock_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Readings from the converter, one channel per valid cycle.
  input wire logic rdg_valid_i,
  input wire logic [4:0] rdg_chan_i,
  input wire logic [cam_pkg::RDG_W-1:0] rdg_value_i,
  // Serial poll pulse from the bus interface logic.
  input wire logic serial_poll_i,
  // Outputs.
  output logic [cam_pkg::NUM_LINES-1:0] alarm_lines_o,
  output logic system_alarm_o,
  output logic service_request_o,
  output logic acq_start_event_o,
  output logic acq_stop_event_o,
  output logic irq_o
);
  import cam_pkg::*;

  // Elaboration checks: the decoders below are sized for these values.
  if (CHANNELS < 1 || CHANNELS > MAX_CH) begin : g_bad_channels
    $error("CHANNELS must lie between 1 and MAX_CH");
  end
  // Channel indices travel as five bits and the alarm query is one word.
  if (MAX_CH > 32) begin : g_bad_max_ch
    $error("MAX_CH must not exceed 32");
  end
  // Both limits share the one limits word.
  if (2 * RDG_W != 32) begin : g_bad_rdg_w
    $error("RDG_W must be half of the limits word");
  end
  // The assign command carries a four-bit line number.
  if (NUM_LINES != 16) begin : g_bad_lines
    $error("NUM_LINES must be 16");
  end
  // Each port fills the low half of one byte of the status word.
  if (PORT_LINES != 4) begin : g_bad_ports
    $error("PORT_LINES must be 4");
  end

  cam_state_t st_ff;
  cam_state_t nxt_st;
  logic [MAX_CH-1:0] chan_alarm;
  logic [MAX_CH-1:0] cfg_hit;
  logic [MAX_CH-1:0] rdg_hit;
  logic req;
  logic wr_now;
  logic rd_now;
  logic full_word;
  logic [4:0] cmd_first;
  logic [4:0] cmd_last;
  logic cfg_we;
  logic asg_we;
  logic [3:0] asg_line;
  logic [31:0] port_word;
  logic [31:0] rd_mux;
  logic any_alarm;
  logic limits_we;
  logic ctrl_we;
  logic mask_we;
  logic stat_rd;
  logic srq_rise;
  logic srq_late;

  // The first cycle of a request loads read data, the second acks it.
  // Registering the answer costs one wait state per access but keeps the
  // read multiplexer off the path to the bus output.
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_now = req && st_ff.ack && wb_we_i;
  assign rd_now = req && st_ff.ack && !wb_we_i;
  // Commands act on whole words only; a partial write could split a range.
  assign full_word = wb_sel_i == 4'hf;
  assign cmd_first = wb_dat_i[CMD_FIRST_LSB +: 5];
  assign cmd_last = wb_dat_i[CMD_LAST_LSB +: 5];
  assign cfg_we = wr_now && full_word && wb_adr_i == REG_CFG_CMD;
  assign asg_we = wr_now && full_word && wb_adr_i == REG_ASSIGN_CMD;
  assign asg_line = wb_dat_i[CMD_ARG_LSB +: 4];
  // Plain register strobes; control and mask live in byte lane 0 only.
  assign limits_we = wr_now && wb_adr_i == REG_LIMITS;
  assign ctrl_we = wr_now && wb_sel_i[0] && wb_adr_i == REG_CTRL;
  assign mask_we = wr_now && wb_sel_i[0] && wb_adr_i == REG_IRQ_MASK;
  assign stat_rd = rd_now && wb_adr_i == REG_IRQ_STATUS;

  // Range decode for both commands and the reading strobe per channel.
  // Channels at or above CHANNELS never match, so a range that runs past
  // the last channel is cut short rather than refused.
  always_comb begin
    cfg_hit = '0;
    rdg_hit = '0;
    for (int c = 0; c < MAX_CH; c++) begin
      cfg_hit[c] = (c < CHANNELS) && (5'(c) >= cmd_first) &&
                   (5'(c) <= cmd_last);
      rdg_hit[c] = rdg_valid_i && (rdg_chan_i == 5'(c)) && (c < CHANNELS);
    end
  end

  // One comparator per channel; unused slots stay silent.
  // Every comparator takes the same limits word, so channels that need
  // other limits are configured by separate commands.
  for (genvar g = 0; g < MAX_CH; g++) begin : g_chan
    if (g < CHANNELS) begin : g_used
      cam_chan u_chan (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .cfg_we_i(cfg_we && cfg_hit[g]),
        .cfg_alarm_en_i(wb_dat_i[CMD_ARG_LSB]),
        .cfg_high_i(st_ff.limits[LIM_HIGH_LSB +: RDG_W]),
        .cfg_low_i(st_ff.limits[LIM_LOW_LSB +: RDG_W]),
        .rdg_valid_i(rdg_hit[g]),
        .rdg_value_i(rdg_value_i),
        .alarm_o(chan_alarm[g])
      );
    end else begin : g_unused
      assign chan_alarm[g] = 1'b0;
    end
  end

  // Pack the four ports, each a weighted sum of its own four lines.
  // Line one of a port is its bit 0, so the byte value is the sum itself.
  always_comb begin
    port_word = '0;
    for (int p = 0; p < NUM_LINES / PORT_LINES; p++) begin
      port_word[p*8 +: 8] =
        {4'h0, st_ff.lines[p*PORT_LINES +: PORT_LINES]};
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  // The write-only command offsets fall into the default as well, and the
  // alarm word shows unused channels as zero.
  always_comb begin
    unique case (wb_adr_i)
      REG_LIMITS: rd_mux = st_ff.limits;
      REG_CTRL: rd_mux = {31'h0, st_ff.srq_en};
      REG_OUT_STATUS: rd_mux = port_word;
      REG_CHAN_ALARM: rd_mux = chan_alarm;
      REG_IRQ_STATUS: rd_mux = {30'h0, st_ff.irq_stat};
      REG_IRQ_MASK: rd_mux = {30'h0, st_ff.irq_mask};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  assign any_alarm = |chan_alarm;

  // Service request is raised on entry to alarm, not held by the alarm
  // level, so that a serial poll really releases it while a channel stays
  // out of limits; the host hears of the next entry only.
  assign srq_rise = st_ff.srq_en && any_alarm && !st_ff.sys_alarm;
  // Turning the enable on during an alarm counts as an entry, or that
  // alarm would go unreported until it ended and came back.
  assign srq_late = ctrl_we && wb_dat_i[CTRL_SRQ_EN_BIT] && !st_ff.srq_en &&
                    any_alarm;

  // Next-state logic for the bus slave, mapping and alarm events.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = req && !st_ff.ack;
    if (req && !st_ff.ack) begin
      nxt_st.rdata = rd_mux;
    end

    // Byte-lane writes to the plain registers.
    if (limits_we) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          nxt_st.limits[b*8 +: 8] = wb_dat_i[b*8 +: 8];
        end
      end
    end
    if (ctrl_we) begin
      nxt_st.srq_en = wb_dat_i[CTRL_SRQ_EN_BIT];
    end
    if (mask_we) begin
      nxt_st.irq_mask = wb_dat_i[1:0];
    end

    // Assign moves the range onto the chosen line and off all others.
    // A channel thus never drives two lines; a later assign of an
    // overlapping range takes the overlap away from the earlier line,
    // while channels outside the range keep their mapping.
    if (asg_we) begin
      for (int l = 0; l < NUM_LINES; l++) begin
        for (int c = 0; c < MAX_CH; c++) begin
          if (cfg_hit[c]) begin
            nxt_st.map[l][c] = (4'(l) == asg_line);
          end
        end
      end
    end

    // Each line is the OR of the alarms mapped onto it.
    for (int l = 0; l < NUM_LINES; l++) begin
      nxt_st.lines[l] = |(st_ff.map[l] & chan_alarm);
    end

    // System alarm and its edges as acquisition events.
    // The events are one-cycle pulses, so a sequencer downstream needs no
    // edge detector of its own, and the alarm limits alone arm them.
    nxt_st.sys_alarm = any_alarm;
    nxt_st.start_ev = any_alarm && !st_ff.sys_alarm;
    nxt_st.stop_ev = !any_alarm && st_ff.sys_alarm;

    // Reading the status clears it, but a new event in that cycle wins.
    if (stat_rd) begin
      nxt_st.irq_stat = 2'h0;
    end
    if (nxt_st.start_ev) begin
      nxt_st.irq_stat[IRQ_ENTER_BIT] = 1'b1;
    end
    if (nxt_st.stop_ev) begin
      nxt_st.irq_stat[IRQ_LEAVE_BIT] = 1'b1;
    end

    // Service request: a serial poll or a cleared enable drops it, and a
    // fresh entry in that same cycle wins so that no entry is ever lost.
    if (serial_poll_i) begin
      nxt_st.srq = 1'b0;
    end
    if (!st_ff.srq_en) begin
      nxt_st.srq = 1'b0;
    end
    if (srq_rise || srq_late) begin
      nxt_st.srq = 1'b1;
    end
  end

  // Register the whole state.
  // Limits and mask take their named reset values; everything else,
  // the channel map included, starts empty.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.limits <= LIMITS_RST;
      st_ff.irq_mask <= IRQ_MASK_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flip-flops, apart from the interrupt level and the read data gated by ack.
  // The interrupt level follows the status and mask registers with no
  // further delay, so it drops in the cycle after the clearing read.
  assign wb_ack_o = st_ff.ack;
  assign wb_dat_o = st_ff.ack ? st_ff.rdata : 32'h0000_0000;
  assign alarm_lines_o = st_ff.lines;
  assign system_alarm_o = st_ff.sys_alarm;
  assign service_request_o = st_ff.srq;
  assign acq_start_event_o = st_ff.start_ev;
  assign acq_stop_event_o = st_ff.stop_ev;
  assign irq_o = |(st_ff.irq_stat & st_ff.irq_mask);

endmodule : cam_mapper
`default_nettype wire

//--- verification/cam_mapper_sva.sv
// Port assertions of the alarm mapper top.
`timescale 1ns/1ns
`default_nettype none
module cam_mapper_sva #(
  parameter int CHANNELS = cam_pkg::MAX_CH
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic serial_poll_i,
  input wire logic [cam_pkg::NUM_LINES-1:0] alarm_lines_o,
  input wire logic system_alarm_o,
  input wire logic service_request_o,
  input wire logic acq_start_event_o,
  input wire logic acq_stop_event_o
);
  import cam_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // A fresh request gets one ack cycle, then ack drops.
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_once: assert property (s_req |=> s_ans)
    else $error("ack not one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  // Events are one pulse on each edge of the alarm state.
  a_start_rise: assert property (acq_start_event_o == $rose(system_alarm_o))
    else $error("start event mismatch");
  a_stop_fall: assert property (acq_stop_event_o == $fell(system_alarm_o))
    else $error("stop event mismatch");
  a_lines_alarm: assert property (|alarm_lines_o |-> system_alarm_o)
    else $error("line without alarm");
  // A poll releases the request unless a new alarm entry wins.
  a_srq_release: assert property (serial_poll_i && !wb_cyc_i |=>
    !service_request_o || $rose(system_alarm_o))
    else $error("request kept after poll");
  a_srq_cause: assert property ($rose(service_request_o) |->
    $rose(system_alarm_o) || $past(wb_ack_o))
    else $error("request without cause");
endmodule : cam_mapper_sva
`default_nettype wire

//--- verification/cam_host_model.sv
// Bus controller model that serial-polls on service request.
`timescale 1ns/1ns
`default_nettype none
module cam_host_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic srq_i,
  input wire logic slow_i,
  output logic poll_o,
  output logic ready_o
);
  logic [3:0] wait_ff;
  logic [3:0] boot_ff;
  // Poll delay varies so prompt and late answers are both seen.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wait_ff <= 4'h0;
      boot_ff <= 4'h0;
      poll_o <= 1'b0;
    end else begin
      poll_o <= 1'b0;
      if (boot_ff != 4'hf) boot_ff <= boot_ff + 4'h1;
      if (!srq_i || poll_o) wait_ff <= 4'h0;
      else if (wait_ff == (slow_i ? 4'h9 : 4'h1)) begin
        poll_o <= 1'b1;
        wait_ff <= 4'h0;
      end else wait_ff <= wait_ff + 4'h1;
    end
  end
  // Configuration waits until the post-reset status says ready.
  assign ready_o = (boot_ff == 4'hf);
endmodule : cam_host_model
`default_nettype wire

//--- verification/cam_mapper_tb.sv
// Self-checking bench of the alarm mapper with a polling controller.
`timescale 1ns/1ns
`default_nettype none
module cam_mapper_tb;
  import cam_pkg::*;
  localparam int HI = 18;
  localparam int LO = 1;
  logic clock_i = 0, rst_i = 1, cyc = 0, wen = 0, rv = 0, slow = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, q, fl = 32'h0;
  logic [4:0] rch = 5'h0;
  logic [15:0] rval = 16'h0, lines;
  logic ack, poll, sys, srq, irq, ready;
  int err_total = 0, checks_done = 0, seed = 28;
  int tbl[4] = '{0, 1, 2, 20};
  int edge_v[4] = '{HI, HI + 1, LO, LO - 1};
  cam_mapper i_dut (.clock_i(clock_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(wen), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wd), .wb_dat_o(q), .wb_ack_o(ack), .rdg_valid_i(rv),
    .rdg_chan_i(rch), .rdg_value_i(rval), .serial_poll_i(poll),
    .alarm_lines_o(lines), .system_alarm_o(sys),
    .service_request_o(srq), .acq_start_event_o(),
    .acq_stop_event_o(), .irq_o(irq));
  cam_host_model i_host (.clock_i(clock_i), .rst_i(rst_i), .srq_i(srq),
    .slow_i(slow), .poll_o(poll), .ready_o(ready));
  // Bench clock of 8 ns.
  always #4 clock_i = ~clock_i;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic report_and_stop();
    if (err_total == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  // One classic cycle; the request holds until ack is sampled.
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge clock_i);
    cyc <= 1'b1;
    wen <= w;
    adr <= a;
    wd <= d;
    do @(posedge clock_i); while (ack !== 1'b1);
    r = q;
    cyc <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rd
  // One reading; armed channels are 0 to 15 only.
  task automatic feed(input int c, input int v);
    @(posedge clock_i);
    rv <= 1'b1;
    rch <= c[4:0];
    rval <= v[15:0];
    @(posedge clock_i);
    rv <= 1'b0;
    fl[c] = (c < 16) && (v > HI || v < LO);
    repeat (3) @(posedge clock_i);
  endtask : feed
  // Line 1 ORs channels 0 and 1, line 6 follows channel 2.
  function automatic logic [15:0] exp_lines(input logic [31:0] f);
    return {10'h0, f[2], 4'h0, f[0] | f[1]};
  endfunction : exp_lines
  function automatic logic [31:0] exp_out(input logic [15:0] l);
    return {4'h0, l[15:12], 4'h0, l[11:8], 4'h0, l[7:4], 4'h0, l[3:0]};
  endfunction : exp_out
  // Reset, configure, boundary readings first, then random ones.
  initial begin
    logic [31:0] r;
    int c;
    int v;
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    while (ready !== 1'b1) @(posedge clock_i);
    rd(REG_LIMITS, LIMITS_RST);
    rd(REG_IRQ_MASK, 32'h0);
    rd(8'h20, 32'h0);
    wb(1'b1, REG_LIMITS, {16'(HI), 16'(LO)}, r);
    wb(1'b1, REG_CFG_CMD, 32'h0001_0f00, r);
    wb(1'b1, REG_ASSIGN_CMD, 32'h0000_0100, r);
    wb(1'b1, REG_ASSIGN_CMD, 32'h0005_0202, r);
    wb(1'b1, REG_CTRL, 32'h1, r);
    for (int i = 0; i < 60; i++) begin
      c = i < 4 ? 0 : tbl[$unsigned($random(seed)) % 4];
      v = i < 4 ? edge_v[i] : $random(seed) % 40;
      slow <= 1'($random(seed));
      feed(c, v);
      chk(sys, |fl);
      chk(lines, exp_lines(fl));
      rd(REG_CHAN_ALARM, fl);
      rd(REG_OUT_STATUS, exp_out(exp_lines(fl)));
    end
    for (int i = 0; i < 3; i++) feed(i, 5);
    wb(1'b0, REG_IRQ_STATUS, 32'h0, r);
    // A late poll leaves room to see the request before it is released.
    slow <= 1'b1;
    feed(0, 30);
    chk(irq, 1'b0);
    chk(srq, 1'b1);
    repeat (12) @(posedge clock_i);
    chk(srq, 1'b0);
    chk(sys, 1'b1);
    rd(REG_IRQ_STATUS, 32'h1);
    rd(REG_IRQ_STATUS, 32'h0);
    wb(1'b1, REG_IRQ_MASK, 32'h3, r);
    feed(0, 5);
    chk(irq, 1'b1);
    rd(REG_IRQ_STATUS, 32'h2);
    @(posedge clock_i);
    chk(irq, 1'b0);
    wb(1'b1, REG_CFG_CMD, 32'h0, r);
    feed(0, 30);
    chk(sys, 1'b0);
    repeat (20) @(posedge clock_i);
    chk(srq, 1'b0);
    report_and_stop();
  end
  // Cuts a hang short; the run needs well under 4000 cycles.
  initial begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    report_and_stop();
  end
endmodule : cam_mapper_tb
bind cam_mapper cam_mapper_sva #(.CHANNELS(CHANNELS)) i_sva (
  .clock_i(clock_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .serial_poll_i(serial_poll_i), .alarm_lines_o(alarm_lines_o),
  .system_alarm_o(system_alarm_o), .service_request_o(service_request_o),
  .acq_start_event_o(acq_start_event_o),
  .acq_stop_event_o(acq_stop_event_o));
`default_nettype wire
